//--- verification/cbm_mem_chk_asserts.sv
// Purpose: port-level checks for the block memory
// Assumes: config inputs held static while a port is busy
// Notes: latencies count from the edge that takes a request
`timescale 1ns/1ps
`default_nettype none
module cbm_mem_chk
   import cbm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_global_clear_n,
   input wire logic i_port_a_output_clear,
   input wire logic i_port_b_output_clear,
   input wire logic [1:0] i_mem_mode,
   input wire logic [2:0] i_a_width,
   input wire logic [2:0] i_b_width,
   input wire logic [1:0] i_a_wr_mode,
   input wire logic i_a_out_reg,
   input wire logic i_b_out_reg,
   input wire logic i_init_we,
   input wire logic i_a_ce,
   input wire logic i_a_we,
   input wire logic [35:0] i_a_wdata,
   input wire logic i_b_ce,
   input wire logic [35:0] o_a_rdata,
   input wire logic [35:0] o_b_rdata,
   input wire logic o_cfg_error
);
   logic a_clr;
   logic a_wr;
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);
   // low bits owned by a port of the given width
   function automatic logic [35:0] wmask(input logic [2:0] w);
      case (w)
         CBM_W1: return 36'h0_0000_0001;
         CBM_W2: return 36'h0_0000_0003;
         CBM_W4: return 36'h0_0000_000F;
         CBM_W9: return 36'h0_0000_01FF;
         CBM_W18: return 36'h0_0003_FFFF;
         default: return 36'hF_FFFF_FFFF;
      endcase
   endfunction
   // preload wins over a user write, so such a write is not counted
   assign a_clr = !i_global_clear_n || i_port_a_output_clear;
   // a 36-wide port in true dual stays idle, so its writes are not counted
   assign a_wr = i_a_ce && i_a_we && !i_init_we && i_mem_mode != 2'h3 &&
      !(i_mem_mode == CBM_TRUE_DUAL && i_a_width == CBM_W36);
   AST_A_WR_HOLD: assert property (disable iff (!i_arst_n || a_clr)
      a_wr && !i_a_out_reg && (i_a_wr_mode == CBM_WR_NORMAL ||
      (i_a_wr_mode == CBM_WR_READ_FIRST && i_a_width < CBM_W9)) |-> ##2 $stable(o_a_rdata))
      else $error("port A output moved on a holding write");
   AST_A_WR_THRU: assert property (disable iff (!i_arst_n || a_clr)
      a_wr && !i_a_out_reg && i_a_wr_mode == CBM_WR_THROUGH
      |-> ##2 o_a_rdata == ($past(i_a_wdata, 2) & wmask(i_a_width)))
      else $error("write data not shown on port A");
   AST_A_CHG_CAUSE: assert property (disable iff (!i_arst_n || a_clr)
      $changed(o_a_rdata) |-> (i_a_out_reg ? $past(i_a_ce, 3) : $past(i_a_ce, 2)))
      else $error("port A output changed without a request");
   AST_B_CHG_CAUSE: assert property (disable iff (!i_arst_n || !i_global_clear_n || i_port_b_output_clear)
      $changed(o_b_rdata) |-> (i_b_out_reg ? $past(i_b_ce, 3) : $past(i_b_ce, 2)))
      else $error("port B output changed at the wrong latency");
   AST_A_LOCAL_CLR: assert property (i_port_a_output_clear |-> o_a_rdata == '0)
      else $error("port A output not cleared");
   AST_B_LOCAL_CLR: assert property (i_port_b_output_clear |-> o_b_rdata == '0)
      else $error("port B output not cleared");
   AST_GLOBAL_CLR: assert property (!i_global_clear_n |-> (o_a_rdata | o_b_rdata) == '0)
      else $error("global clear left an output set");
   AST_CFG_X36_DUAL: assert property (
      i_mem_mode == CBM_TRUE_DUAL && (i_a_width == CBM_W36 || i_b_width == CBM_W36)
      |=> o_cfg_error)
      else $error("x36 in true dual not flagged");
   AST_CFG_NARROW_RF: assert property (
      i_a_wr_mode == CBM_WR_READ_FIRST && i_a_width < CBM_W9 |=> o_cfg_error)
      else $error("narrow read-first not flagged");
endmodule // cbm_mem_chk
bind cbm_block_mem cbm_mem_chk chk_u
(
   .i_sys_clk(i_sys_clk),
   .i_arst_n(i_arst_n),
   .i_global_clear_n(i_global_clear_n),
   .i_port_a_output_clear(i_port_a_output_clear),
   .i_port_b_output_clear(i_port_b_output_clear),
   .i_mem_mode(i_mem_mode),
   .i_a_width(i_a_width),
   .i_b_width(i_b_width),
   .i_a_wr_mode(i_a_wr_mode),
   .i_a_out_reg(i_a_out_reg),
   .i_b_out_reg(i_b_out_reg),
   .i_init_we(i_init_we),
   .i_a_ce(i_a_ce),
   .i_a_we(i_a_we),
   .i_a_wdata(i_a_wdata),
   .i_b_ce(i_b_ce),
   .o_a_rdata(o_a_rdata),
   .o_b_rdata(o_b_rdata),
   .o_cfg_error(o_cfg_error)
);
`default_nettype wire

//--- verification/cbm_user_model.sv
// Purpose: user logic driving both memory ports
// Assumes: one request per call, driven at the next rising edge and taken at the one after
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module cbm_user_model
(
   input wire logic i_sys_clk,
   output var logic [1:0] o_ce,
   output var logic [1:0] o_we,
   output var logic [1:0][12:0] o_addr,
   output var logic [1:0][35:0] o_wdata
);
   // idle at time zero
   initial
   begin
      o_ce = '0;
      o_we = '0;
      o_addr = '0;
      o_wdata = '0;
   end
   // request held whole through its sampling edge, then scrambled so
   // that a port sampling late picks up garbage, not the request
   task automatic acc(input int p, input logic w, input logic [12:0] ad, input logic [35:0] d);
      @(posedge i_sys_clk);
      o_ce[p] <= 1'b1;
      o_we[p] <= w;
      o_addr[p] <= ad;
      o_wdata[p] <= d;
      @(posedge i_sys_clk);
      o_ce[p] <= 1'b0;
      o_we[p] <= 1'b0;
      o_addr[p] <= ~ad;
      o_wdata[p] <= ~d;
   endtask
endmodule // cbm_user_model
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: self-checking bench for the block memory
// Assumes: config inputs change only while both ports are idle
// Notes: a bit-level copy of the array gives each expected read word; clears expect zero, write-through the written data
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cbm_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic gclr_n = 1'b1;
   logic [1:0] clr = '0;
   logic [1:0] mode = '0;
   logic [2:0] a_wid = 3'h5;
   logic [2:0] b_wid = 3'h5;
   logic [1:0] a_wm = '0;
   logic [1:0] b_wm = '0;
   logic [1:0] oreg = '0;
   logic init_we = 1'b0;
   logic [7:0] init_row = '0;
   logic [35:0] init_data = '0;
   logic [1:0] ce;
   logic [1:0] we;
   logic [1:0][12:0] addr;
   logic [1:0][35:0] wdata;
   logic [35:0] o_a;
   logic [35:0] o_b;
   logic cfg_err;
   logic [35:0] mem [256];
   logic [35:0] pat [4] = '{36'h1_2345_67C9, 36'h8_9ABC_DEF0, 36'h3_C3C3_C3C3, 36'hF_0F0F_0F0F};
   int wb [6] = '{1, 2, 4, 9, 18, 36};
   int dp [6] = '{8192, 4096, 2048, 1024, 512, 256};
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   // 25 MHz
   always #20 clk = ~clk;
   cbm_block_mem dut_u (.i_sys_clk(clk), .i_arst_n(rst_n), .i_global_clear_n(gclr_n),
      .i_port_a_output_clear(clr[0]), .i_port_b_output_clear(clr[1]), .i_mem_mode(mode),
      .i_a_width(a_wid), .i_b_width(b_wid), .i_a_wr_mode(a_wm), .i_b_wr_mode(b_wm),
      .i_a_out_reg(oreg[0]), .i_b_out_reg(oreg[1]), .i_init_we(init_we),
      .i_init_row(init_row), .i_init_data(init_data), .i_a_ce(ce[0]), .i_a_we(we[0]),
      .i_a_addr(addr[0]), .i_a_wdata(wdata[0]), .i_b_ce(ce[1]), .i_b_we(we[1]),
      .i_b_addr(addr[1]), .i_b_wdata(wdata[1]), .o_a_rdata(o_a), .o_b_rdata(o_b),
      .o_cfg_error(cfg_err));
   cbm_user_model user_u (.i_sys_clk(clk), .o_ce(ce), .o_we(we), .o_addr(addr),
      .o_wdata(wdata));
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // word n of a w-bit port: bits run word after word through the rows
   function automatic logic [35:0] word(input int w, input int n);
      logic [35:0] r;
      r = '0;
      for (int k = 0; k < w; k++)
         r[k] = mem[(n * w + k) / 36][(n * w + k) % 36];
      return r;
   endfunction
   task automatic put(input int w, input int n, input logic [35:0] d);
      for (int k = 0; k < w; k++)
         mem[(n * w + k) / 36][(n * w + k) % 36] = d[k];
   endtask
   task automatic pre(input int r, input logic [35:0] d);
      @(posedge clk);
      init_we <= 1'b1;
      init_row <= r[7:0];
      init_data <= d;
      mem[r] = d;
      @(posedge clk);
      init_we <= 1'b0;
   endtask
   // config only moves while idle, then settles for two edges
   task automatic cfg(input logic [1:0] m, input logic [2:0] aw, input logic [2:0] bw,
      input logic [1:0] am, input logic [1:0] ors);
      @(posedge clk);
      mode <= m;
      a_wid <= aw;
      b_wid <= bw;
      a_wm <= am;
      oreg <= ors;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic op(input int p, input logic w, input int n, input logic [35:0] d);
      user_u.acc(p, w, n[12:0], d);
      repeat (1 + oreg[p]) @(posedge clk);
      #1;
   endtask
   task automatic t_layout;
      for (int s = 0; s < 6; s++)
      begin
         cfg(CBM_PSEUDO_DUAL, CBM_W9, s[2:0], CBM_WR_NORMAL, 2'b00);
         op(1, 1'b0, 3 + dp[s], '0);
         chk(o_b, word(wb[s], 3));
      end
      op(0, 1'b1, 5, 36'h0_0000_016B);
      put(9, 5, 36'h0_0000_016B);
      op(1, 1'b0, 1, '0);
      chk(o_b, word(36, 1));
      $display("layout test done");
   endtask
   task automatic t_wmodes;
      logic [2:0] ws [4] = '{CBM_W4, CBM_W1, CBM_W18, CBM_W2};
      logic [1:0] ms [4] = '{CBM_WR_NORMAL, CBM_WR_THROUGH, CBM_WR_READ_FIRST, CBM_WR_READ_FIRST};
      logic [35:0] held;
      logic [35:0] old;
      logic [35:0] d;
      int w;
      for (int i = 0; i < 4; i++)
      begin
         cfg(CBM_SINGLE, ws[i], CBM_W36, ms[i], 2'b00);
         w = wb[ws[i]];
         held = word(w, 3);
         old = word(w, 2);
         d = ~held & ((36'h0_0000_0001 << w) - 1);
         op(0, 1'b0, 3, '0);
         chk(o_a, held);
         op(0, 1'b1, 2, d);
         chk(o_a, ms[i] == CBM_WR_THROUGH ? d : (i == 2 ? old : held));
         put(w, 2, d);
         op(0, 1'b0, 2, '0);
         chk(o_a, d);
      end
      chk({35'h0, cfg_err}, 36'h0_0000_0001);
      $display("write mode test done");
   endtask
   task automatic t_outreg;
      cfg(CBM_PSEUDO_DUAL, CBM_W9, CBM_W36, CBM_WR_NORMAL, 2'b10);
      op(1, 1'b0, 0, '0);
      chk(o_b, word(36, 0));
      user_u.acc(1, 1'b0, 13'h0003, '0);
      @(posedge clk);
      #1;
      chk(o_b, word(36, 0));
      @(posedge clk);
      #1;
      chk(o_b, word(36, 3));
      $display("output register test done");
   endtask
   task automatic t_clear;
      cfg(CBM_TRUE_DUAL, CBM_W18, CBM_W9, CBM_WR_NORMAL, 2'b00);
      op(0, 1'b0, 1, '0);
      op(1, 1'b0, 4, '0);
      @(posedge clk);
      clr <= 2'b01;
      #1;
      chk(o_a, '0);
      chk(o_b, word(9, 4));
      @(posedge clk);
      clr <= 2'b00;
      gclr_n <= 1'b0;
      #1;
      chk(o_a | o_b, '0);
      @(posedge clk);
      gclr_n <= 1'b1;
      op(0, 1'b0, 1, '0);
      chk(o_a, word(18, 1));
      op(1, 1'b0, 4, '0);
      chk(o_b, word(9, 4));
      // b's local clear must leave port a's output alone
      @(posedge clk);
      clr <= 2'b10;
      #1;
      chk(o_b, '0);
      chk(o_a, word(18, 1));
      @(posedge clk);
      clr <= 2'b00;
      // port b write-through in true dual, then read back
      @(posedge clk);
      b_wm <= CBM_WR_THROUGH;
      op(1, 1'b1, 6, 36'h0_0000_00A5);
      chk(o_b, 36'h0_0000_00A5);
      put(9, 6, 36'h0_0000_00A5);
      op(1, 1'b0, 6, '0);
      chk(o_b, word(9, 6));
      $display("clear test done");
   endtask
   task automatic t_cfg;
      cfg(CBM_TRUE_DUAL, CBM_W36, CBM_W9, CBM_WR_NORMAL, 2'b00);
      chk({35'h0, cfg_err}, 36'h0_0000_0001);
      cfg(CBM_SINGLE, CBM_W36, CBM_W9, CBM_WR_NORMAL, 2'b00);
      chk({35'h0, cfg_err}, '0);
      $display("shape check test done");
   endtask
   // a hung request must not stall the run
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_errors++;
         tally_and_finish;
      end
   end
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(o_a | o_b, '0);
      chk({35'h0, cfg_err}, '0);
      for (int r = 0; r < 4; r++)
         pre(r, pat[r]);
      t_layout;
      t_wmodes;
      t_outreg;
      t_clear;
      t_cfg;
      tally_and_finish;
   end
endmodule // tb_top
`default_nettype wire

//--- verilog/cbm_block_mem.sv
// Purpose: embedded block memory with single, true dual and pseudo dual modes
// Assumes: configuration inputs are static during user operation
// Notes: both ports share i_sys_clk; the preload port models configuration
`timescale 1ns/1ps
`default_nettype none
module cbm_block_mem
   import cbm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_global_clear_n,
   input wire logic i_port_a_output_clear,
   input wire logic i_port_b_output_clear,
   input wire logic [1:0] i_mem_mode,
   input wire logic [2:0] i_a_width,
   input wire logic [2:0] i_b_width,
   input wire logic [1:0] i_a_wr_mode,
   input wire logic [1:0] i_b_wr_mode,
   input wire logic i_a_out_reg,
   input wire logic i_b_out_reg,
   input wire logic i_init_we,
   input wire logic [7:0] i_init_row,
   input wire logic [35:0] i_init_data,
   input wire logic i_a_ce,
   input wire logic i_a_we,
   input wire logic [12:0] i_a_addr,
   input wire logic [35:0] i_a_wdata,
   input wire logic i_b_ce,
   input wire logic i_b_we,
   input wire logic [12:0] i_b_addr,
   input wire logic [35:0] i_b_wdata,
   output logic [35:0] o_a_rdata,
   output logic [35:0] o_b_rdata,
   output logic o_cfg_error
);
   typedef struct packed
   {
      logic a_ce;
      logic a_we;
      logic [12:0] a_addr;
      logic [35:0] a_wdata;
      logic b_ce;
      logic b_we;
      logic [12:0] b_addr;
      logic [35:0] b_wdata;
      logic cfg_error;
   } cbm_state_t;

   // data bits per word for a width selection
   function automatic logic [5:0] word_bits(input logic [2:0] sel);
      case (cbm_width_t'(sel))
         CBM_W1: word_bits = 6'h01;
         CBM_W2: word_bits = 6'h02;
         CBM_W4: word_bits = 6'h04;
         CBM_W9: word_bits = 6'h09;
         CBM_W18: word_bits = 6'h12;
         CBM_W36: word_bits = 6'h24;
         default: word_bits = 6'h01;
      endcase
   endfunction

   // highest usable address; upper bits beyond the depth are dropped
   function automatic logic [12:0] addr_mask(input logic [2:0] sel);
      case (cbm_width_t'(sel))
         CBM_W1: addr_mask = 13'h1fff;
         CBM_W2: addr_mask = 13'h0fff;
         CBM_W4: addr_mask = 13'h07ff;
         CBM_W9: addr_mask = 13'h03ff;
         CBM_W18: addr_mask = 13'h01ff;
         CBM_W36: addr_mask = 13'h00ff;
         default: addr_mask = 13'h1fff;
      endcase
   endfunction

   // lane mask covering one word in the low bits
   function automatic logic [35:0] data_mask(input logic [2:0] sel);
      case (cbm_width_t'(sel))
         CBM_W1: data_mask = 36'h0_0000_0001;
         CBM_W2: data_mask = 36'h0_0000_0003;
         CBM_W4: data_mask = 36'h0_0000_000f;
         CBM_W9: data_mask = 36'h0_0000_01ff;
         CBM_W18: data_mask = 36'h0_0003_ffff;
         CBM_W36: data_mask = 36'hf_ffff_ffff;
         default: data_mask = 36'h0_0000_0001;
      endcase
   endfunction

   // linear bit index of a word: word n starts at bit n times width
   function automatic logic [13:0] bit_index(input logic [12:0] addr, input logic [2:0] sel);
      logic [26:0] prod;
      prod = 27'(addr & addr_mask(sel)) * 27'(word_bits(sel));
      bit_index = prod[13:0];
   endfunction

   // every width divides 36, so a word never straddles two rows
   function automatic logic [7:0] row_of(input logic [13:0] idx);
      logic [13:0] q;
      q = idx / CBM_ROW_BITS;
      row_of = q[7:0];
   endfunction

   function automatic logic [5:0] col_of(input logic [13:0] idx);
      logic [13:0] r;
      r = idx % CBM_ROW_BITS;
      col_of = r[5:0];
   endfunction

   // splice one word into a row at its column
   function automatic logic [35:0] merge_word(input logic [35:0] row_val,
                                              input logic [5:0] col,
                                              input logic [2:0] sel,
                                              input logic [35:0] data);
      logic [35:0] m;
      m = data_mask(sel);
      merge_word = (row_val & ~(m << col)) | ((data & m) << col);
   endfunction

   // read-before-write is offered only on the wide, parity-style shapes
   function automatic logic rbw_ok(input logic [2:0] sel);
      rbw_ok = (sel == CBM_W9) || (sel == CBM_W18) || (sel == CBM_W36);
   endfunction

   logic [35:0] mem [0:255];
   cbm_state_t st_ff;
   cbm_state_t nxt_st;

   logic [7:0] a_row;
   logic [5:0] a_col;
   logic [7:0] b_row;
   logic [5:0] b_col;
   logic [35:0] a_old;
   logic [35:0] b_old;
   logic a_wr;
   logic a_rd;
   logic b_wr;
   logic b_rd;
   logic a_bad;
   logic b_bad;
   logic [35:0] a_row_new;
   logic [35:0] b_row_new;
   logic a_load;
   logic b_load;
   logic [35:0] a_value;
   logic [35:0] b_value;
   logic a_clr_n;
   logic b_clr_n;

   // input capture: user requests reach the array only through a register stage; the preload port writes it directly
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.a_ce = i_a_ce;
      nxt_st.a_we = i_a_we;
      nxt_st.a_addr = i_a_addr;
      nxt_st.a_wdata = i_a_wdata;
      nxt_st.b_ce = i_b_ce;
      nxt_st.b_we = i_b_we;
      nxt_st.b_addr = i_b_addr;
      nxt_st.b_wdata = i_b_wdata;
      nxt_st.cfg_error = a_bad || b_bad;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // shape legality: 36-wide only outside true dual, read-first only wide
   always_comb
   begin
      a_bad = 1'b0;
      b_bad = 1'b0;
      if (cbm_mode_t'(i_mem_mode) == CBM_TRUE_DUAL)
      begin
         a_bad = (i_a_width == CBM_W36);
         b_bad = (i_b_width == CBM_W36);
      end
      if ((i_a_wr_mode == CBM_WR_READ_FIRST) && !rbw_ok(i_a_width))
      begin
         a_bad = 1'b1;
      end
      if ((i_b_wr_mode == CBM_WR_READ_FIRST) && !rbw_ok(i_b_width))
      begin
         b_bad = 1'b1;
      end
      if (i_a_width > CBM_W36)
      begin
         a_bad = 1'b1;
      end
      if (i_b_width > CBM_W36)
      begin
         b_bad = 1'b1;
      end
   end

   // each port locates its word with its own width over one shared array
   always_comb
   begin
      a_row = row_of(bit_index(st_ff.a_addr, i_a_width));
      a_col = col_of(bit_index(st_ff.a_addr, i_a_width));
      b_row = row_of(bit_index(st_ff.b_addr, i_b_width));
      b_col = col_of(bit_index(st_ff.b_addr, i_b_width));
      a_old = (mem[a_row] >> a_col) & data_mask(i_a_width);
      b_old = (mem[b_row] >> b_col) & data_mask(i_b_width);
   end

   // port roles per mode; a bad 36-wide shape in true dual stays idle
   always_comb
   begin
      a_wr = 1'b0;
      a_rd = 1'b0;
      b_wr = 1'b0;
      b_rd = 1'b0;
      case (cbm_mode_t'(i_mem_mode))
         CBM_SINGLE:
         begin
            a_wr = st_ff.a_ce && st_ff.a_we;
            a_rd = st_ff.a_ce && !st_ff.a_we;
         end
         CBM_TRUE_DUAL:
         begin
            a_wr = st_ff.a_ce && st_ff.a_we && (i_a_width != CBM_W36);
            a_rd = st_ff.a_ce && !st_ff.a_we && (i_a_width != CBM_W36);
            b_wr = st_ff.b_ce && st_ff.b_we && (i_b_width != CBM_W36);
            b_rd = st_ff.b_ce && !st_ff.b_we && (i_b_width != CBM_W36);
         end
         CBM_PSEUDO_DUAL:
         begin
            a_wr = st_ff.a_ce && st_ff.a_we;
            b_rd = st_ff.b_ce;
         end
         default:
         begin
            a_wr = 1'b0;
         end
      endcase
      // configuration preload owns the array while it runs
      if (i_init_we)
      begin
         a_wr = 1'b0;
         b_wr = 1'b0;
      end
   end

   // row images after this cycle's writes; b sees a's change on a shared row
   always_comb
   begin
      a_row_new = merge_word(mem[a_row], a_col, i_a_width, st_ff.a_wdata);
      if (a_wr && (a_row == b_row))
      begin
         b_row_new = merge_word(a_row_new, b_col, i_b_width, st_ff.b_wdata);
      end
      else
      begin
         b_row_new = merge_word(mem[b_row], b_col, i_b_width, st_ff.b_wdata);
      end
   end

   // array: no reset, so clears never disturb stored contents
   always_ff @(posedge i_sys_clk)
   begin
      if (i_init_we)
      begin
         mem[i_init_row] <= i_init_data;
      end
      if (a_wr)
      begin
         mem[a_row] <= a_row_new;
      end
      if (b_wr)
      begin
         mem[b_row] <= b_row_new;
      end
   end

   // what each port's output latch takes this cycle, per write mode
   always_comb
   begin
      a_load = a_rd;
      a_value = a_old;
      if (a_wr)
      begin
         case (cbm_wr_mode_t'(i_a_wr_mode))
            CBM_WR_NORMAL:
            begin
               a_load = 1'b0;
            end
            CBM_WR_THROUGH:
            begin
               a_load = 1'b1;
               a_value = st_ff.a_wdata & data_mask(i_a_width);
            end
            CBM_WR_READ_FIRST:
            begin
               a_load = rbw_ok(i_a_width);
            end
            default:
            begin
               a_load = 1'b0;
            end
         endcase
      end
   end

   always_comb
   begin
      b_load = b_rd;
      b_value = b_old;
      if (b_wr)
      begin
         case (cbm_wr_mode_t'(i_b_wr_mode))
            CBM_WR_NORMAL:
            begin
               b_load = 1'b0;
            end
            CBM_WR_THROUGH:
            begin
               b_load = 1'b1;
               b_value = st_ff.b_wdata & data_mask(i_b_width);
            end
            CBM_WR_READ_FIRST:
            begin
               b_load = rbw_ok(i_b_width);
            end
            default:
            begin
               b_load = 1'b0;
            end
         endcase
      end
   end

   // clears are asynchronous: local one per port, global and system for both
   assign a_clr_n = i_arst_n && i_global_clear_n && !i_port_a_output_clear;
   assign b_clr_n = i_arst_n && i_global_clear_n && !i_port_b_output_clear;

   cbm_out_stage u_out_a
   (
      .i_sys_clk(i_sys_clk),
      .i_clr_n(a_clr_n),
      .i_load(a_load),
      .i_rd_value(a_value),
      .i_use_out_reg(i_a_out_reg),
      .o_rdata(o_a_rdata)
   );

   cbm_out_stage u_out_b
   (
      .i_sys_clk(i_sys_clk),
      .i_clr_n(b_clr_n),
      .i_load(b_load),
      .i_rd_value(b_value),
      .i_use_out_reg(i_b_out_reg),
      .o_rdata(o_b_rdata)
   );

   assign o_cfg_error = st_ff.cfg_error;
endmodule // cbm_block_mem
`default_nettype wire

//--- verilog/cbm_out_stage.sv
// Purpose: per-port output latch with optional output register
// Assumes: i_clr_n is the combined asynchronous clear for this port
// Notes: the output flop mirrors the latch, or lags it one clock
`timescale 1ns/1ps
`default_nettype none
module cbm_out_stage
   import cbm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_clr_n,
   input wire logic i_load,
   input wire logic [35:0] i_rd_value,
   input wire logic i_use_out_reg,
   output logic [35:0] o_rdata
);
   typedef struct packed
   {
      logic [35:0] latch;
      logic [35:0] out;
   } cbm_out_state_t;

   cbm_out_state_t st_ff;
   cbm_out_state_t nxt_st;

   // latch holds unless a read value is offered; out register adds a clock
   always_comb
   begin
      nxt_st = st_ff;
      if (i_load)
      begin
         nxt_st.latch = i_rd_value;
      end
      nxt_st.out = i_use_out_reg ? st_ff.latch : nxt_st.latch;
   end

   // clear touches only this port's output, never the array
   always_ff @(posedge i_sys_clk or negedge i_clr_n)
   begin
      if (!i_clr_n)
      begin
         st_ff.latch <= CBM_DATA_RST;
         st_ff.out <= CBM_DATA_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign o_rdata = st_ff.out;
endmodule // cbm_out_stage
`default_nettype wire

//--- verilog/cbm_pkg.sv
// Purpose: shared constants and types for the configurable block memory
// Assumes: one clock for both ports; configuration inputs are held static
// Notes: the array is 256 rows of 36 bits, addressed linearly by bit index
package cbm_pkg;
   localparam int unsigned CBM_ROW_W = 36;
   localparam int unsigned CBM_ROWS = 256;
   localparam int unsigned CBM_ROW_AW = 8;
   localparam int unsigned CBM_COL_W = 6;
   localparam int unsigned CBM_ADDR_W = 13;
   localparam int unsigned CBM_BIT_IDX_W = 14;
   localparam logic [13:0] CBM_ROW_BITS = 14'h0024;
   localparam logic [35:0] CBM_DATA_RST = 36'h0_0000_0000;
   // width selections: each names one depth x width shape
   typedef enum logic [2:0]
   {
      CBM_W1 = 3'h0,
      CBM_W2 = 3'h1,
      CBM_W4 = 3'h2,
      CBM_W9 = 3'h3,
      CBM_W18 = 3'h4,
      CBM_W36 = 3'h5
   } cbm_width_t;
   typedef enum logic [1:0]
   {
      CBM_SINGLE = 2'h0,
      CBM_TRUE_DUAL = 2'h1,
      CBM_PSEUDO_DUAL = 2'h2
   } cbm_mode_t;
   typedef enum logic [1:0]
   {
      CBM_WR_NORMAL = 2'h0,
      CBM_WR_THROUGH = 2'h1,
      CBM_WR_READ_FIRST = 2'h2
   } cbm_wr_mode_t;
endpackage
